//--- hdl/hbw_unit.sv
// Hardware instruction breakpoints, data watchpoints and resource watchpoints with a Wishbone register slave.
//
// Operation
// - Debug interrupt when executing PC equals an enabled breakpoint's address register.
// - Four instruction breakpoints, each with its own address and control register.
// - Breakpoint control selects permitted threads and the firing condition.
// - Control bits 23:16 are a per-thread mask, reset zero, gating each comparator.
// - Control bit 0 enables the comparator; resets to zero.
// - Breakpoint bit 1: zero fires on PC equal, one on PC not equal.
// - Four first data watch addresses at indices 0x50 to 0x53.
// - Four second data watch addresses at indices 0x60 to 0x63.
// - Four data watch control registers with enable, condition, load and mask.
// - Data control bit 2 makes the watchpoint trigger on loads; resets zero.
// - Data control bit 1: zero needs A and B, one needs A or B.
// - Four 32-bit resource watch masks.
// - Four 32-bit resource watch comparison values.
// - Four resource control registers; bit 1 picks condition A or B.
// - Cause code 3 for instruction, 4 for data, 5 for resource watch.
// - Data watch captures the effective address of the memory operation.
// - Resource watch captures the resource identifier into the same register.
//
// Local design decision: the Wishbone slave port.
module hbw_unit
  import hbw_pkg::*;
(
  // Clock, reset and enable
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        clkEn,
  // Wishbone slave
  input  wire logic                        wbCyc,
  input  wire logic                        wbStb,
  input  wire logic                        wbWe,
  input  wire logic [hbw_pkg::ADDR_W-1:0]  wbAdr,
  input  wire logic [3:0]                  wbSel,
  input  wire logic [31:0]                 wbDatI,
  output logic      [31:0]                 wbDatO,
  output logic                             wbAck,
  // Pipeline: instruction issue
  input  wire logic                        instValid,
  input  wire logic [31:0]                 instPc,
  input  wire logic [hbw_pkg::THREAD_W-1:0] instThread,
  // Pipeline: memory operation
  input  wire logic                        memValid,
  input  wire logic                        memLoad,
  input  wire logic [31:0]                 memAddr,
  input  wire logic [hbw_pkg::THREAD_W-1:0] memThread,
  // Pipeline: resource use
  input  wire logic                        resValid,
  input  wire logic [31:0]                 resId,
  input  wire logic [hbw_pkg::THREAD_W-1:0] resThread,
  // Debug interrupt
  output logic                             debugIrq
);
  import hbw_pkg::*;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [31:0] ibAddr  [NUM_CMP];
  logic [31:0] ibCtrl  [NUM_CMP];
  logic [31:0] dwAddrA [NUM_CMP];
  logic [31:0] dwAddrB [NUM_CMP];
  logic [31:0] dwCtrl  [NUM_CMP];
  logic [31:0] rwMask  [NUM_CMP];
  logic [31:0] rwValue [NUM_CMP];
  logic [31:0] rwCtrl  [NUM_CMP];
  logic [31:0] causeReg;
  logic [31:0] dataReg;

  // Byte-lane merge for partial writes.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel,
                                        input logic [31:0] keep);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r & keep;
  endfunction : merge

  // True when the comparator is enabled and the thread's mask bit is set.
  function automatic logic armed(input logic [31:0] ctrl, input logic [THREAD_W-1:0] thr);
    logic [NUM_THREAD-1:0] m;
    m = ctrl[MASK_MSB:MASK_LSB];
    return ctrl[BIT_ENABLE] & m[thr];
  endfunction : armed

  // ----------------------------------------------------------------
  // Wishbone decode
  // ----------------------------------------------------------------
  logic       req;
  logic       wrEn;
  logic [7:0] idx;
  logic [7:0] sub;
  logic [1:0] n;

  assign req  = wbCyc & wbStb & ~wbAck;
  assign wrEn = req & wbWe & clkEn;
  assign idx  = wbAdr[ADDR_W-1:2];
  assign n    = idx[IDX_W-1:0];
  assign sub  = {idx[7:2], 2'b00};

  always_ff @(posedge clk) begin
    if (rst) begin
      wbAck <= 1'b0;
    end else if (clkEn) begin
      wbAck <= req;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wbDatO <= 32'h0000_0000;
    end else if (clkEn && req) begin
      unique case (sub)
        IDX_IBRK_ADDR: wbDatO <= ibAddr[n];
        IDX_IBRK_CTRL: wbDatO <= ibCtrl[n];
        IDX_DW_ADDR_A: wbDatO <= dwAddrA[n];
        IDX_DW_ADDR_B: wbDatO <= dwAddrB[n];
        IDX_DW_CTRL:   wbDatO <= dwCtrl[n];
        IDX_RW_MASK:   wbDatO <= rwMask[n];
        IDX_RW_VALUE:  wbDatO <= rwValue[n];
        IDX_RW_CTRL:   wbDatO <= rwCtrl[n];
        default: begin
          if (idx == IDX_CAUSE) begin
            wbDatO <= causeReg;
          end else if (idx == IDX_DATA) begin
            wbDatO <= dataReg;
          end else begin
            wbDatO <= 32'h0000_0000;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Comparator registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_CMP; i++) begin
        ibAddr[i]  <= 32'h0000_0000;
        ibCtrl[i]  <= CTRL_RESET;
        dwAddrA[i] <= 32'h0000_0000;
        dwAddrB[i] <= 32'h0000_0000;
        dwCtrl[i]  <= CTRL_RESET;
        rwMask[i]  <= 32'h0000_0000;
        rwValue[i] <= 32'h0000_0000;
        rwCtrl[i]  <= CTRL_RESET;
      end
    end else if (wrEn) begin
      unique case (sub)
        IDX_IBRK_ADDR: ibAddr[n]  <= merge(ibAddr[n], wbDatI, wbSel, 32'hFFFF_FFFF);
        IDX_IBRK_CTRL: ibCtrl[n]  <= merge(ibCtrl[n], wbDatI, wbSel, IBRK_CTRL_MASK);
        IDX_DW_ADDR_A: dwAddrA[n] <= merge(dwAddrA[n], wbDatI, wbSel, 32'hFFFF_FFFF);
        IDX_DW_ADDR_B: dwAddrB[n] <= merge(dwAddrB[n], wbDatI, wbSel, 32'hFFFF_FFFF);
        IDX_DW_CTRL:   dwCtrl[n]  <= merge(dwCtrl[n], wbDatI, wbSel, DW_CTRL_MASK);
        IDX_RW_MASK:   rwMask[n]  <= merge(rwMask[n], wbDatI, wbSel, 32'hFFFF_FFFF);
        IDX_RW_VALUE:  rwValue[n] <= merge(rwValue[n], wbDatI, wbSel, 32'hFFFF_FFFF);
        IDX_RW_CTRL:   rwCtrl[n]  <= merge(rwCtrl[n], wbDatI, wbSel, RW_CTRL_MASK);
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Match logic
  // ----------------------------------------------------------------
  logic [NUM_CMP-1:0] ibHit;
  logic [NUM_CMP-1:0] dwHit;
  logic [NUM_CMP-1:0] rwHit;

  always_comb begin
    logic eq;
    logic ca;
    logic cb;
    eq = 1'b0;
    ca = 1'b0;
    cb = 1'b0;
    for (int i = 0; i < NUM_CMP; i++) begin
      eq = (instPc == ibAddr[i]);
      ibHit[i] = instValid & armed(ibCtrl[i], instThread) & (ibCtrl[i][BIT_COND] ? ~eq : eq);
      ca = (memAddr == dwAddrA[i]);
      cb = (memAddr == dwAddrB[i]);
      dwHit[i] = memValid & armed(dwCtrl[i], memThread) & (memLoad ? dwCtrl[i][BIT_LOAD] : 1'b1)
                 & (dwCtrl[i][BIT_COND] ? (ca | cb) : (ca & cb));
      ca = ((resId & rwMask[i]) == (rwValue[i] & rwMask[i]));
      rwHit[i] = resValid & armed(rwCtrl[i], resThread) & (rwCtrl[i][BIT_COND] ? ~ca : ca);
    end
  end

  // Lowest set bit index of a hit vector.
  function automatic logic [IDX_W-1:0] lowest(input logic [NUM_CMP-1:0] v);
    logic [IDX_W-1:0] r;
    r = '0;
    for (int i = NUM_CMP - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = IDX_W'(i);
      end
    end
    return r;
  endfunction : lowest

  // ----------------------------------------------------------------
  // Cause capture and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      causeReg <= 32'h0000_0000;
      dataReg  <= 32'h0000_0000;
      debugIrq <= 1'b0;
    end else if (clkEn) begin
      debugIrq <= |{ibHit, dwHit, rwHit};
      if (|ibHit) begin
        causeReg <= {14'h0, lowest(ibHit), 5'h0, instThread, 5'h0, CAUSE_IBRK};
      end else if (|dwHit) begin
        causeReg <= {14'h0, lowest(dwHit), 5'h0, memThread, 5'h0, CAUSE_DATA};
        dataReg  <= memAddr;
      end else if (|rwHit) begin
        causeReg <= {14'h0, lowest(rwHit), 5'h0, resThread, 5'h0, CAUSE_RES};
        dataReg  <= resId;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_ibHit0;
    clkEn && instValid && ibCtrl[0][BIT_ENABLE] && !ibCtrl[0][BIT_COND] && instPc == ibAddr[0]
      && ibCtrl[0][MASK_LSB + int'(instThread)];
  endsequence

  property p_ibrk_fire;
    @(posedge clk) disable iff (rst) s_ibHit0 |=> debugIrq && causeReg[2:0] == CAUSE_IBRK;
  endproperty
  a_ibrk_fire: assert property (p_ibrk_fire) else $error("breakpoint 0 match did not interrupt");

  property p_disabled_quiet;
    @(posedge clk) disable iff (rst)
      clkEn && !ibCtrl[0][BIT_ENABLE] && !ibCtrl[1][BIT_ENABLE] && !ibCtrl[2][BIT_ENABLE] && !ibCtrl[3][BIT_ENABLE]
      && !memValid && !resValid |=> !debugIrq;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("interrupt with all comparators off");

  property p_mask_gate;
    @(posedge clk) disable iff (rst)
      clkEn && ibCtrl[0][MASK_MSB:MASK_LSB] == 8'h00 && ibCtrl[1][MASK_MSB:MASK_LSB] == 8'h00
      && ibCtrl[2][MASK_MSB:MASK_LSB] == 8'h00 && ibCtrl[3][MASK_MSB:MASK_LSB] == 8'h00
      && !memValid && !resValid |=> !debugIrq;
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("interrupt with empty thread masks");

  property p_ne_sense;
    @(posedge clk) disable iff (rst)
      clkEn && instValid && ibCtrl[0][BIT_ENABLE] && ibCtrl[0][BIT_COND] && instPc != ibAddr[0]
      && ibCtrl[0][MASK_LSB + int'(instThread)] |=> debugIrq && causeReg[17:16] == 2'h0;
  endproperty
  a_ne_sense: assert property (p_ne_sense) else $error("not-equal breakpoint missed");

  property p_store_only;
    @(posedge clk) disable iff (rst)
      clkEn && !instValid && !resValid && memValid && memLoad && !dwCtrl[0][BIT_LOAD] && !dwCtrl[1][BIT_LOAD]
      && !dwCtrl[2][BIT_LOAD] && !dwCtrl[3][BIT_LOAD] |=> !debugIrq;
  endproperty
  a_store_only: assert property (p_store_only) else $error("load fired with load bit clear");

  property p_data_capture;
    @(posedge clk) disable iff (rst)
      clkEn && !(|ibHit) && (|dwHit) |=> dataReg == $past(memAddr) && causeReg[2:0] == CAUSE_DATA;
  endproperty
  a_data_capture: assert property (p_data_capture) else $error("data watch capture wrong");

  property p_res_capture;
    @(posedge clk) disable iff (rst)
      clkEn && !(|ibHit) && !(|dwHit) && (|rwHit) |=> dataReg == $past(resId) && causeReg[2:0] == CAUSE_RES;
  endproperty
  a_res_capture: assert property (p_res_capture) else $error("resource watch capture wrong");

  property p_lowest;
    @(posedge clk) disable iff (rst)
      clkEn && ibHit[1] && ibHit[3] && !ibHit[0] |=> causeReg[17:16] == 2'h1;
  endproperty
  a_lowest: assert property (p_lowest) else $error("lowest index not recorded");

  property p_ack_one;
    @(posedge clk) disable iff (rst) wbAck |=> !wbAck;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held two cycles");

  property p_ack_after_req;
    @(posedge clk) disable iff (rst) clkEn && wbCyc && wbStb && !wbAck |=> wbAck;
  endproperty
  a_ack_after_req: assert property (p_ack_after_req) else $error("request not acknowledged");

  property p_irq_from_hit;
    @(posedge clk) disable iff (rst) clkEn && (|{ibHit, dwHit, rwHit}) |=> debugIrq;
  endproperty
  a_irq_from_hit: assert property (p_irq_from_hit) else $error("hit without interrupt");

  property p_irq_no_hit;
    @(posedge clk) disable iff (rst) clkEn && !(|{ibHit, dwHit, rwHit}) |=> !debugIrq;
  endproperty
  a_irq_no_hit: assert property (p_irq_no_hit) else $error("interrupt without hit");

  property p_ib_thread;
    @(posedge clk) disable iff (rst) clkEn && (|ibHit) |=> causeReg[CAUSE_THR_LSB +: THREAD_W] == $past(instThread);
  endproperty
  a_ib_thread: assert property (p_ib_thread) else $error("breakpoint thread not recorded");

  property p_dw_thread;
    @(posedge clk) disable iff (rst)
      clkEn && !(|ibHit) && (|dwHit) |=> causeReg[CAUSE_THR_LSB +: THREAD_W] == $past(memThread);
  endproperty
  a_dw_thread: assert property (p_dw_thread) else $error("data watch thread not recorded");

  property p_rw_thread;
    @(posedge clk) disable iff (rst)
      clkEn && !(|ibHit) && !(|dwHit) && (|rwHit) |=> causeReg[CAUSE_THR_LSB +: THREAD_W] == $past(resThread);
  endproperty
  a_rw_thread: assert property (p_rw_thread) else $error("resource watch thread not recorded");

  property p_ib_first;
    @(posedge clk) disable iff (rst) clkEn && ibHit[0] |=> causeReg[CAUSE_IDX_LSB +: IDX_W] == '0;
  endproperty
  a_ib_first: assert property (p_ib_first) else $error("breakpoint 0 not preferred");

  property p_ib_priority;
    @(posedge clk) disable iff (rst) clkEn && (|ibHit) && (|dwHit) |=> causeReg[2:0] == CAUSE_IBRK;
  endproperty
  a_ib_priority: assert property (p_ib_priority) else $error("breakpoint cause not preferred");

  property p_dw_or;
    @(posedge clk) disable iff (rst)
      memValid && !memLoad && dwCtrl[0][BIT_ENABLE] && dwCtrl[0][BIT_COND] && dwCtrl[0][MASK_LSB + int'(memThread)]
      && memAddr == dwAddrA[0] |-> dwHit[0];
  endproperty
  a_dw_or: assert property (p_dw_or) else $error("either-address watch missed");

  property p_dw_and;
    @(posedge clk) disable iff (rst) memValid && !dwCtrl[0][BIT_COND] && memAddr != dwAddrB[0] |-> !dwHit[0];
  endproperty
  a_dw_and: assert property (p_dw_and) else $error("both-address watch fired on one");

  property p_dw_load;
    @(posedge clk) disable iff (rst) memValid && memLoad && !dwCtrl[0][BIT_LOAD] |-> !dwHit[0];
  endproperty
  a_dw_load: assert property (p_dw_load) else $error("load seen with load bit clear");

  property p_rw_cond_a;
    @(posedge clk) disable iff (rst)
      resValid && rwCtrl[0][BIT_ENABLE] && !rwCtrl[0][BIT_COND] && rwCtrl[0][MASK_LSB + int'(resThread)]
      && (resId & rwMask[0]) == (rwValue[0] & rwMask[0]) |-> rwHit[0];
  endproperty
  a_rw_cond_a: assert property (p_rw_cond_a) else $error("resource match missed");

  property p_rw_cond_b;
    @(posedge clk) disable iff (rst)
      resValid && rwCtrl[0][BIT_COND] && (resId & rwMask[0]) == (rwValue[0] & rwMask[0]) |-> !rwHit[0];
  endproperty
  a_rw_cond_b: assert property (p_rw_cond_b) else $error("resource differ fired on equal");

  property p_ib_mask_zero;
    @(posedge clk) disable iff (rst) ibCtrl[0][MASK_MSB:MASK_LSB] == '0 |-> !ibHit[0];
  endproperty
  a_ib_mask_zero: assert property (p_ib_mask_zero) else $error("breakpoint fired with empty mask");

  property p_dw_off;
    @(posedge clk) disable iff (rst) !dwCtrl[0][BIT_ENABLE] |-> !dwHit[0];
  endproperty
  a_dw_off: assert property (p_dw_off) else $error("disabled data watch fired");

  property p_rw_off;
    @(posedge clk) disable iff (rst) !rwCtrl[0][BIT_ENABLE] |-> !rwHit[0];
  endproperty
  a_rw_off: assert property (p_rw_off) else $error("disabled resource watch fired");

endmodule : hbw_unit

//--- hdl/hbw_pkg.sv
// Package with register map, field layout and cause codes of the breakpoint and watchpoint unit.
package hbw_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_CMP      = 4;
  localparam int NUM_THREAD   = 8;
  localparam int IDX_W        = 2;
  localparam int THREAD_W     = 3;
  localparam int ADDR_W       = 10;

  // ----------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_IBRK_ADDR  = 8'h30;
  localparam logic [7:0] IDX_IBRK_CTRL  = 8'h40;
  localparam logic [7:0] IDX_DW_ADDR_A  = 8'h50;
  localparam logic [7:0] IDX_DW_ADDR_B  = 8'h60;
  localparam logic [7:0] IDX_DW_CTRL    = 8'h70;
  localparam logic [7:0] IDX_RW_MASK    = 8'h80;
  localparam logic [7:0] IDX_RW_VALUE   = 8'h90;
  localparam logic [7:0] IDX_RW_CTRL    = 8'h9C;
  localparam logic [7:0] IDX_CAUSE      = 8'h15;
  localparam logic [7:0] IDX_DATA       = 8'h16;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int BIT_ENABLE   = 0;
  localparam int BIT_COND     = 1;
  localparam int BIT_LOAD     = 2;
  localparam int MASK_LSB     = 16;
  localparam int MASK_MSB     = 23;
  localparam logic [31:0] IBRK_CTRL_MASK = 32'h00FF_0003;
  localparam logic [31:0] DW_CTRL_MASK   = 32'h00FF_0007;
  localparam logic [31:0] RW_CTRL_MASK   = 32'h00FF_0003;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Cause register layout and codes
  // ----------------------------------------------------------------
  localparam int CAUSE_IDX_LSB = 16;
  localparam int CAUSE_THR_LSB = 8;
  localparam logic [2:0] CAUSE_NONE  = 3'h0;
  localparam logic [2:0] CAUSE_IBRK  = 3'h3;
  localparam logic [2:0] CAUSE_DATA  = 3'h4;
  localparam logic [2:0] CAUSE_RES   = 3'h5;

endpackage : hbw_pkg

//--- dv/hbw_pipe_model.sv
// Pipeline model that issues instructions, memory operations and resource uses.
module hbw_pipe_model
  import hbw_pkg::*;
(
  // Clock
  input  wire logic                          clk,
  // Issue groups
  output logic                               instValid,
  output logic [31:0]                        instPc,
  output logic [hbw_pkg::THREAD_W-1:0]      instThread,
  output logic                               memValid,
  output logic                               memLoad,
  output logic [31:0]                        memAddr,
  output logic [hbw_pkg::THREAD_W-1:0]      memThread,
  output logic                               resValid,
  output logic [31:0]                        resId,
  output logic [hbw_pkg::THREAD_W-1:0]      resThread
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {instValid, memValid, resValid, memLoad} = 4'h0;
    {instPc, memAddr, resId} = '0;
    {instThread, memThread, resThread} = '0;
  end

  // One group is valid for one cycle; released lines then show inverted values.
  task automatic issue(input logic [1:0] g, input logic [31:0] v, input logic [2:0] th, input logic ld);
    case (g)
      2'd0: begin instValid <= 1'b1; instPc <= v; instThread <= th; end
      2'd1: begin memValid <= 1'b1; memAddr <= v; memThread <= th; memLoad <= ld; end
      default: begin resValid <= 1'b1; resId <= v; resThread <= th; end
    endcase
    @(posedge clk);
    {instValid, memValid, resValid} <= 3'b000;
    instPc <= ~instPc;
    memAddr <= ~memAddr;
    resId <= ~resId;
    memLoad <= ~memLoad;
  endtask : issue
endmodule : hbw_pipe_model

//--- dv/hbw_unit_bench.sv
// Self-checking bench of the breakpoint and watchpoint unit.
module hbw_unit_bench
  import hbw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  clk = 1'b0, rst = 1'b1, clkEn = 1'b1;
  logic                  wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic [ADDR_W-1:0]     wbAdr = '0;
  logic [3:0]            wbSel = 4'h0;
  logic [31:0]           wbDatI = '0, wbDatO, instPc, memAddr, resId, r, a, b;
  logic                  wbAck, debugIrq, instValid, memValid, memLoad, resValid;
  logic [THREAD_W-1:0]   instThread, memThread, resThread;
  logic [39:0]           notes[$];
  logic [39:0]           note;
  logic [7:0]            base[8];
  logic [31:0]           msk[8];
  int                    fails = 0, checksDone = 0, irqSeen = 0;
  int                    seed = 32'h75a1_5d96;

  always #4 clk = ~clk;

  hbw_unit hbw_unit_inst (.clk(clk), .rst(rst), .clkEn(clkEn), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck), .instValid(instValid),
    .instPc(instPc), .instThread(instThread), .memValid(memValid), .memLoad(memLoad), .memAddr(memAddr),
    .memThread(memThread), .resValid(resValid), .resId(resId), .resThread(resThread), .debugIrq(debugIrq));

  hbw_pipe_model hbw_pipe_model_inst (.clk(clk), .instValid(instValid), .instPc(instPc),
    .instThread(instThread), .memValid(memValid), .memLoad(memLoad), .memAddr(memAddr),
    .memThread(memThread), .resValid(resValid), .resId(resId), .resThread(resThread));

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  // Watches read answers and interrupt pulses half a cycle after they settle.
  always @(negedge clk) begin
    if (debugIrq === 1'b1) irqSeen++;
    if (wbAck === 1'b1 && wbWe === 1'b0 && notes.size() > 0) begin
      note = notes.pop_front();
      chk($sformatf("reg %h", note[39:32]), wbDatO, note[31:0]);
    end
  end

  // ----------------------------------------------------------------
  // Register bus master
  // ----------------------------------------------------------------
  task automatic wb(input logic we, input logic [7:0] idx, input logic [31:0] d, input logic [3:0] sel);
    int n;
    n = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= {idx, 2'b00};
    wbSel <= sel;
    wbDatI <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      end_sim();
    end
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clk);
  endtask : wb

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    wb(1'b1, idx, d, 4'hf);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    notes.push_back({idx, exp});
    wb(1'b0, idx, 32'h0000_0000, 4'hf);
  endtask : rd

  function automatic logic [31:0] cz(input logic [2:0] c, input logic [1:0] i, input logic [2:0] t);
    return {14'h0000, i, 5'h00, t, 5'h00, c};
  endfunction : cz

  // Sets one control register, issues one operation and checks interrupt, cause and capture.
  task automatic trig(input logic [7:0] ci, input logic [31:0] ctl, input logic [1:0] g, input logic [31:0] v,
                      input logic [2:0] th, input logic ld, input int e, input logic [31:0] cause, input bit wd);
    wr(ci, ctl);
    hbw_pipe_model_inst.issue(g, v, th, ld);
    repeat (2) @(posedge clk);
    chk("irq count", 32'(irqSeen), 32'(e));
    irqSeen = 0;
    if (e > 0) begin
      rd(IDX_CAUSE, cause);
      if (wd) rd(IDX_DATA, v);
    end
  endtask : trig

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    base = '{IDX_IBRK_ADDR, IDX_IBRK_CTRL, IDX_DW_ADDR_A, IDX_DW_ADDR_B, IDX_DW_CTRL, IDX_RW_MASK,
             IDX_RW_VALUE, IDX_RW_CTRL};
    msk = '{32'hFFFF_FFFF, IBRK_CTRL_MASK, 32'hFFFF_FFFF, 32'hFFFF_FFFF, DW_CTRL_MASK, 32'hFFFF_FFFF,
            32'hFFFF_FFFF, RW_CTRL_MASK};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      rd(8'(IDX_IBRK_CTRL + k), CTRL_RESET);
      rd(8'(IDX_DW_CTRL + k), CTRL_RESET);
      rd(8'(IDX_RW_CTRL + k), CTRL_RESET);
    end
    rd(8'h00, 32'h0000_0000);
    foreach (base[i]) for (int k = 0; k < 4; k++) begin
      r = $random(seed);
      wr(8'(base[i] + k), r);
      rd(8'(base[i] + k), r & msk[i]);
    end
    wr(IDX_RW_VALUE, 32'hAAAA_AAAA);
    wb(1'b1, IDX_RW_VALUE, 32'h1122_3344, 4'b0010);
    rd(IDX_RW_VALUE, 32'hAAAA_33AA);
    wr(IDX_CAUSE, 32'hFFFF_FFFF);
    rd(IDX_CAUSE, 32'h0000_0000);
    foreach (base[i]) if (msk[i] != 32'hFFFF_FFFF) for (int k = 0; k < 4; k++) wr(8'(base[i] + k), 32'h0);
    a = $random(seed);
    wr(IDX_IBRK_ADDR + 8'd1, a);
    wr(IDX_IBRK_ADDR + 8'd3, a);
    wr(IDX_IBRK_CTRL + 8'd1, 32'h0004_0001);
    trig(IDX_IBRK_CTRL + 8'd3, 32'h0004_0001, 0, a, 2, 0, 1, cz(3, 1, 2), 0);
    trig(IDX_IBRK_CTRL + 8'd1, 32'h0004_0000, 0, a, 2, 0, 1, cz(3, 3, 2), 0);
    trig(IDX_IBRK_CTRL + 8'd3, 32'h0004_0001, 0, a, 3, 0, 0, 0, 0);
    trig(IDX_IBRK_CTRL + 8'd3, 32'h0004_0003, 0, a, 2, 0, 0, 0, 0);
    trig(IDX_IBRK_CTRL + 8'd3, 32'h0004_0003, 0, ~a, 2, 0, 1, cz(3, 3, 2), 0);
    clkEn <= 1'b0;
    hbw_pipe_model_inst.issue(0, ~a, 2, 0);
    repeat (2) @(posedge clk);
    chk("frozen irq count", 32'(irqSeen), 32'h0000_0000);
    irqSeen = 0;
    clkEn <= 1'b1;
    @(posedge clk);
    wr(IDX_IBRK_CTRL + 8'd3, 32'h0);
    b = a ^ 32'h0000_0010;
    wr(IDX_DW_ADDR_A + 8'd2, a);
    wr(IDX_DW_ADDR_B + 8'd2, b);
    trig(IDX_DW_CTRL + 8'd2, 32'h0020_0003, 1, b, 5, 0, 1, cz(4, 2, 5), 1);
    trig(IDX_DW_CTRL + 8'd2, 32'h0020_0001, 1, a, 5, 0, 0, 0, 0);
    trig(IDX_DW_CTRL + 8'd2, 32'h0020_0003, 1, a, 5, 1, 0, 0, 0);
    trig(IDX_DW_CTRL + 8'd2, 32'h0020_0007, 1, a, 5, 1, 1, cz(4, 2, 5), 1);
    wr(IDX_DW_ADDR_B + 8'd2, a);
    trig(IDX_DW_CTRL + 8'd2, 32'h0020_0001, 1, a, 5, 0, 1, cz(4, 2, 5), 1);
    wr(IDX_DW_CTRL + 8'd2, 32'h0);
    wr(IDX_RW_MASK, 32'h0000_FF00);
    wr(IDX_RW_VALUE, 32'h0000_1200);
    trig(IDX_RW_CTRL, 32'h0080_0001, 2, 32'hABCD_12EF, 7, 0, 1, cz(5, 0, 7), 1);
    trig(IDX_RW_CTRL, 32'h0080_0003, 2, 32'hABCD_12EF, 7, 0, 0, 0, 0);
    trig(IDX_RW_CTRL, 32'h0080_0003, 2, 32'h0000_3400, 7, 0, 1, cz(5, 0, 7), 1);
    end_sim();
  end
endmodule : hbw_unit_bench
